//--- epcif_cfg.svh
`ifndef EPCIF_CFG_SVH
`define EPCIF_CFG_SVH
// ==================================================================
// Register indices (byte address is four times the index).
`define EPCIF_IDX_PC_ENABLE  12'h068
`define EPCIF_IDX_PC_MASK0   12'h06B
`define EPCIF_IDX_PC_MASK1   12'h06C
`define EPCIF_IDX_PC_MASK2   12'h06D
`define EPCIF_IDX_EXT_SENSE  12'h069
`define EPCIF_IDX_EXT_ENABLE 12'h03D
`define EPCIF_IDX_EXT_FLAGS  12'h03C
`define EPCIF_IDX_PC_FLAGS   12'h03B
`define EPCIF_IDX_IRQ_STATUS 12'h070
`define EPCIF_IDX_IRQ_CLEAR  12'h071
`define EPCIF_IDX_IRQ_ENABLE 12'h072
`define EPCIF_IDX_SHIFT      2
// ==================================================================
// Widths, field positions and reset values.
`define EPCIF_ADDR_W         12
`define EPCIF_NPINS          25
`define EPCIF_PC_LSB         2
`define EPCIF_G0_MSB         9
`define EPCIF_G1_LSB         10
`define EPCIF_G1_MSB         16
`define EPCIF_G2_LSB         17
`define EPCIF_G2_MSB         24
`define EPCIF_SENSE0_MSB     1
`define EPCIF_SENSE0_LSB     0
`define EPCIF_SENSE1_MSB     3
`define EPCIF_SENSE1_LSB     2
`define EPCIF_RST2           2'h0
`define EPCIF_RST3           3'h0
`define EPCIF_RST4           4'h0
`define EPCIF_RST5           5'h00
`define EPCIF_RST7           7'h00
`define EPCIF_RST8           8'h00
`define EPCIF_RST25          25'h0000000
`define EPCIF_RST32          32'h00000000
`define EPCIF_ARM_DONE       3'h7
`define EPCIF_ARM_STEP       3'h1
`endif

//--- epcif_pkg.sv
// ==================================================================
// Shared types of the pin interrupt flag block.
package epcif_pkg;
   // Trigger selection of a dedicated pin, in sense-field order.
   typedef enum logic [1:0] {
      EPCIF_SENSE_LOW,
      EPCIF_SENSE_CHANGE,
      EPCIF_SENSE_FALL,
      EPCIF_SENSE_RISE
   } epcif_sense_t;
endpackage

//--- epcif_irq_flags.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "epcif_cfg.svh"
// ==================================================================
module epcif_irq_flags (
   // Clock and reset.
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   // APB slave.
   input  wire logic [`EPCIF_ADDR_W-1:0] paddr,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // External pins.
   input  wire logic [1:0]               extPin,
   input  wire logic [7:0]               group0Inputs,
   input  wire logic [6:0]               group1Inputs,
   input  wire logic [7:0]               group2Inputs,
   // Core side.
   input  wire logic                     globalIrqEnable,
   input  wire logic [1:0]               extVectorTaken,
   input  wire logic [2:0]               groupVectorTaken,
   output logic      [1:0]               extPinRequest,
   output logic      [2:0]               groupRequest,
   output logic                          irq
);

   // ===============================================================
   // Decode helpers.

   // True when the byte address selects the register of this index.
   // Only whole words are decoded; a byte address that is not a multiple
   // of four never matches and is answered as unmapped.
   function automatic logic epcif_hit(input logic [`EPCIF_ADDR_W-1:0] a,
                                      input logic [`EPCIF_ADDR_W-1:0] idx);
      epcif_hit = (a == (idx << `EPCIF_IDX_SHIFT));
   endfunction

   // Edge or change trigger of a dedicated pin; low level never triggers here.
   // Low-level mode is handled apart, because it sets no flag at all.
   function automatic logic epcif_trig(input epcif_pkg::epcif_sense_t m,
                                       input logic prev,
                                       input logic cur);
      case (m)
         epcif_pkg::EPCIF_SENSE_CHANGE: epcif_trig = prev ^ cur;
         epcif_pkg::EPCIF_SENSE_FALL:   epcif_trig = prev & ~cur;
         epcif_pkg::EPCIF_SENSE_RISE:   epcif_trig = ~prev & cur;
         default:                       epcif_trig = 1'b0;
      endcase
   endfunction

   // ===============================================================
   // Storage.
   // Pin bits are packed {group 2, group 1, group 0, dedicated pins}, so the
   // two dedicated pins sit at the bottom and each group keeps its order.
   // Control fields are stored at their used width only, so the unused bits
   // of each word are never stored and cannot read back anything but zero.
   logic [`EPCIF_NPINS-1:0] syncA;
   logic [`EPCIF_NPINS-1:0] syncB;
   logic [`EPCIF_NPINS-1:0] syncC;
   logic [`EPCIF_NPINS-1:0] stable;
   logic [`EPCIF_NPINS-1:0] stablePrev;
   logic [2:0]              armCount;
   logic [2:0]              groupEnable;
   logic [7:0]              mask0;
   logic [6:0]              mask1;
   logic [7:0]              mask2;
   logic [3:0]              senseCtrl;
   logic [1:0]              extEnable;
   logic [1:0]              extFlag;
   logic [2:0]              pcFlag;
   logic [4:0]              irqEnable;

   // ===============================================================
   // Pin sampling.

   wire [`EPCIF_NPINS-1:0] rawPins = {group2Inputs, group1Inputs, group0Inputs, extPin};

   // Three-stage sampling per pin; a level is accepted once B and C agree.
   // The agreement check rejects a level that stands for one sample only,
   // which trades a cycle of latency for immunity to a metastable first
   // stage. A driven pulse of two clock periods or more is always seen.
   // The clock must run for detection, so wake from a stopped clock is not
   // supported here; a stopped-clock wake path lives outside this block.
   // The same filter serves the dedicated pins and the group inputs.
   genvar gi;
   generate
      for (gi = 0; gi < `EPCIF_NPINS; gi = gi + 1) begin : g_pin
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               syncA[gi]      <= 1'b0;
               syncB[gi]      <= 1'b0;
               syncC[gi]      <= 1'b0;
               stable[gi]     <= 1'b0;
               stablePrev[gi] <= 1'b0;
            end else begin
               syncA[gi]      <= rawPins[gi];
               syncB[gi]      <= syncA[gi];
               syncC[gi]      <= syncB[gi];
               stable[gi]     <= (syncB[gi] == syncC[gi]) ? syncC[gi] : stable[gi];
               stablePrev[gi] <= stable[gi];
            end
         end
      end
   endgenerate

   // Detection waits until the samplers hold real pin levels, so the
   // reset value of the chain does not fake a change after release.
   // A pin that already sits high at release is taken as its idle level
   // and raises no flag; only later changes count.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         armCount <= `EPCIF_RST3;
      end else if (armCount != `EPCIF_ARM_DONE) begin
         armCount <= armCount + `EPCIF_ARM_STEP;
      end
   end

   // Once armed, the block stays armed until the next reset.
   wire armed = (armCount == `EPCIF_ARM_DONE);
   // Changes are held off until armed, for every pin alike.
   // direction not considered
   wire [`EPCIF_NPINS-1:0] pinChange = armed ? (stable ^ stablePrev) : `EPCIF_RST25;

   // ===============================================================
   // APB decode.
   // Register map, one 32-bit word per register at byte address index*4:
   //  - group enable, the three masks, pin sense and pin enable are read/write;
   //  - pin flags and group flags clear where a one is written, zero is kept;
   //  - the status word shows {group flags, pin flags} and ignores writes;
   //  - the clear word has the status layout, clears on one and reads zero;
   //  - the summary enable word selects which status bits drive irq.
   // Unmapped or unaligned addresses answer with pslverr and read zero.
   wire apbAccess = psel & penable;
   wire apbDone   = apbAccess & pready;
   wire wrEn      = apbDone & pwrite;

   wire selPcEn   = epcif_hit(paddr, `EPCIF_IDX_PC_ENABLE);
   wire selMask0  = epcif_hit(paddr, `EPCIF_IDX_PC_MASK0);
   wire selMask1  = epcif_hit(paddr, `EPCIF_IDX_PC_MASK1);
   wire selMask2  = epcif_hit(paddr, `EPCIF_IDX_PC_MASK2);
   wire selSense  = epcif_hit(paddr, `EPCIF_IDX_EXT_SENSE);
   wire selExtEn  = epcif_hit(paddr, `EPCIF_IDX_EXT_ENABLE);
   wire selExtFl  = epcif_hit(paddr, `EPCIF_IDX_EXT_FLAGS);
   wire selPcFl   = epcif_hit(paddr, `EPCIF_IDX_PC_FLAGS);
   wire selIrqSt  = epcif_hit(paddr, `EPCIF_IDX_IRQ_STATUS);
   wire selIrqClr = epcif_hit(paddr, `EPCIF_IDX_IRQ_CLEAR);
   wire selIrqEn  = epcif_hit(paddr, `EPCIF_IDX_IRQ_ENABLE);
   wire addrHit   = selPcEn | selMask0 | selMask1 | selMask2 | selSense | selExtEn
                  | selExtFl | selPcFl | selIrqSt | selIrqClr | selIrqEn;

   // Read mux; narrow registers sit low and everything above reads zero.
   // The clear word is left out of the mux on purpose: it reads as zero,
   // so a read-modify-write of it can never clear a flag by accident.
   // unused bits zero
   wire [31:0] readData =
        selPcEn  ? {29'h00000000, groupEnable}
      : selMask0 ? {24'h000000, mask0}
      : selMask1 ? {25'h0000000, mask1}
      : selMask2 ? {24'h000000, mask2}
      : selSense ? {28'h0000000, senseCtrl}
      : selExtEn ? {30'h00000000, extEnable}
      : selExtFl ? {30'h00000000, extFlag}
      : selPcFl  ? {29'h00000000, pcFlag}
      : selIrqSt ? {27'h0000000, pcFlag, extFlag}
      : selIrqEn ? {27'h0000000, irqEnable}
      : `EPCIF_RST32;

   // One wait state: pready rises in the second access cycle.
   // Read data is captured a cycle early and shown only with pready, and is
   // zero at every other time, so a late sample never picks up a stale word.
   // A master that holds psel and penable past pready starts a new wait
   // state and repeats the access, which is harmless for these registers.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         prdata  <= `EPCIF_RST32;
         pslverr <= 1'b0;
      end else begin
         pready  <= apbAccess & ~pready;
         prdata  <= (apbAccess & ~pready & ~pwrite) ? readData : `EPCIF_RST32;
         pslverr <= apbAccess & ~pready & ~addrHit;
      end
   end

   // ===============================================================
   // Control registers.

   // Each field has its own short process, so that a write strobe touches
   // exactly one field and the reset value sits beside its owner.
   // Writes land only at the edge that completes the access phase.

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         groupEnable <= `EPCIF_RST3;
      end else if (wrEn && selPcEn) begin
         groupEnable <= pwdata[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask0 <= `EPCIF_RST8;
      end else if (wrEn && selMask0) begin
         mask0 <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask1 <= `EPCIF_RST7;
      end else if (wrEn && selMask1) begin
         mask1 <= pwdata[6:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask2 <= `EPCIF_RST8;
      end else if (wrEn && selMask2) begin
         mask2 <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         senseCtrl <= `EPCIF_RST4;
      end else if (wrEn && selSense) begin
         senseCtrl <= pwdata[3:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         extEnable <= `EPCIF_RST2;
      end else if (wrEn && selExtEn) begin
         extEnable <= pwdata[1:0];
      end
   end

   // Summary enable; it gates only the irq output.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irqEnable <= `EPCIF_RST5;
      end else if (wrEn && selIrqEn) begin
         irqEnable <= pwdata[4:0];
      end
   end

   // ===============================================================
   // Dedicated pins.
   // In low-level mode the flag is held clear and the request follows the
   // filtered pin level directly, so it stands exactly as long as the pin
   // is low and enabled. Switching a pin from an edge mode into low-level
   // mode drops any pending edge flag at once.

   // The sense field is stored raw and cast, so every code is legal and
   // the four modes need no decode of reserved values.
   // sense field decode
   wire epcif_pkg::epcif_sense_t sense0 =
      epcif_pkg::epcif_sense_t'(senseCtrl[`EPCIF_SENSE0_MSB:`EPCIF_SENSE0_LSB]);
   wire epcif_pkg::epcif_sense_t sense1 =
      epcif_pkg::epcif_sense_t'(senseCtrl[`EPCIF_SENSE1_MSB:`EPCIF_SENSE1_LSB]);

   wire [1:0] levelMode = {sense1 == epcif_pkg::EPCIF_SENSE_LOW,
                           sense0 == epcif_pkg::EPCIF_SENSE_LOW};
   wire [1:0] levelLow  = levelMode & ~stable[1:0];

   // Edge triggers wait for the arm count, like the group changes.
   // pin triggers
   wire [1:0] extSet = {epcif_trig(sense1, stablePrev[1], stable[1]) & armed,
                        epcif_trig(sense0, stablePrev[0], stable[0]) & armed};

   // Both the flag word and the clear word can clear a pin flag; the two
   // share one layout at the bottom, so the same data bits serve both.
   // clear sources
   wire [1:0] extClr = extVectorTaken
                     | ({2{wrEn & selExtFl}} & pwdata[1:0])
                     | ({2{wrEn & selIrqClr}} & pwdata[1:0]);

   // set over clear level forces zero
   wire [1:0] next_extFlag = ((extFlag & ~extClr) | extSet) & ~levelMode;

   // ===============================================================
   // Pin-change groups.
   // A group flag rises on a masked change whether or not the group enable
   // is set; the enable gates only the request. Software can therefore poll
   // a group with its request off and still see that something moved.

   wire [7:0] hit0 = pinChange[`EPCIF_G0_MSB:`EPCIF_PC_LSB] & mask0;
   wire [6:0] hit1 = pinChange[`EPCIF_G1_MSB:`EPCIF_G1_LSB] & mask1;
   wire [7:0] hit2 = pinChange[`EPCIF_G2_MSB:`EPCIF_G2_LSB] & mask2;

   // One changed input is enough; several in one cycle set the flag once.
   // group flag set
   wire [2:0] pcSet = {|hit2, |hit1, |hit0};

   // The clear word carries the group flags in bits 4 to 2, above the pin
   // flags, which matches the layout of the status word.
   // clear sources
   wire [2:0] pcClr = groupVectorTaken
                    | ({3{wrEn & selPcFl}} & pwdata[2:0])
                    | ({3{wrEn & selIrqClr}} & pwdata[4:2]);

   wire [2:0] next_pcFlag = (pcFlag & ~pcClr) | pcSet;

   // ===============================================================
   // Requests and summary interrupt.
   // The summary irq ignores the global bit: it serves a poller or a second
   // controller that masks on its own, and reflects only the status bits
   // selected in the summary enable word.

   wire [1:0] next_extReq = (extFlag | levelLow) & extEnable & {2{globalIrqEnable}};
   wire [2:0] next_groupReq = pcFlag & groupEnable & {3{globalIrqEnable}};
   wire       next_irq = |({pcFlag, extFlag} & irqEnable);

   // Sticky flags. They change only through the next-state terms above, so
   // the set-over-clear priority lives in one place for every source.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         extFlag <= `EPCIF_RST2;
         pcFlag  <= `EPCIF_RST3;
      end else begin
         extFlag <= next_extFlag;
         pcFlag  <= next_pcFlag;
      end
   end

   // Registered outputs. Every request is one cycle behind the flag, enable
   // and global bit that produce it; the core sees no combinational path
   // from the register bus or the pins.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         extPinRequest <= `EPCIF_RST2;
         groupRequest  <= `EPCIF_RST3;
         irq           <= 1'b0;
      end else begin
         extPinRequest <= next_extReq;
         groupRequest  <= next_groupReq;
         irq           <= next_irq;
      end
   end

endmodule

//--- epcif_pin_model.sv
`timescale 1ns/1ps
// ==================================================================
// Surrounding circuitry that drives the interrupt pins.
module epcif_pin_model (
   // Clock.
   input  wire logic        clk,
   // Pin levels that the bench asks for.
   input  wire logic [24:0] pinTarget,
   // Pins towards the block.
   output logic      [1:0]  extPin,
   output logic      [7:0]  group0Inputs,
   output logic      [6:0]  group1Inputs,
   output logic      [7:0]  group2Inputs
);
   // Pins move only just after an edge, so every level lasts whole cycles.
   // Long driven pulses
   always_ff @(posedge clk) begin
      {group2Inputs, group1Inputs, group0Inputs, extPin} <= pinTarget;
   end
endmodule

//--- epcif_irq_flags_assertions.sv
`timescale 1ns/1ps
`include "epcif_cfg.svh"
// ==================================================================
// Port checker of the pin interrupt flag block.
module epcif_irq_flags_assertions (
   // Clock and reset.
   input wire logic                     clk,
   input wire logic                     sys_rst,
   // Bus.
   input wire logic [`EPCIF_ADDR_W-1:0] paddr,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   // Core side.
   input wire logic                     globalIrqEnable,
   input wire logic [2:0]               groupVectorTaken,
   input wire logic [1:0]               extPinRequest,
   input wire logic [2:0]               groupRequest
);
   localparam logic [11:0] A_EN = `EPCIF_IDX_PC_ENABLE << `EPCIF_IDX_SHIFT;
   localparam logic [11:0] A_M1 = `EPCIF_IDX_PC_MASK1 << `EPCIF_IDX_SHIFT;
   localparam logic [11:0] A_PF = `EPCIF_IDX_PC_FLAGS << `EPCIF_IDX_SHIFT;
   localparam logic [11:0] A_EF = `EPCIF_IDX_EXT_FLAGS << `EPCIF_IDX_SHIFT;
   // A good read is the only place where register contents show.
   wire rdOk = pready && !pwrite && !pslverr;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ready_timing_a: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
      else $error("bus answer not after one wait state");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("answer outside an access phase");
   err_read_zero_a: assert property (pslverr |-> pready && prdata == 32'h00000000)
      else $error("refused access returned data");
   enable_unused_a: assert property (rdOk && paddr == A_EN |-> prdata[31:3] == 29'h0)
      else $error("unused group enable bits set");
   mask1_unused_a: assert property (rdOk && paddr == A_M1 |-> prdata[31:7] == 25'h0)
      else $error("reserved mask bit set");
   flags_unused_a: assert property (rdOk && paddr == A_PF |-> prdata[31:3] == 29'h0)
      else $error("unused group flag bits set");
   ext_flags_unused_a: assert property (rdOk && paddr == A_EF |-> prdata[31:2] == 30'h0)
      else $error("unused pin flag bits set");
   global_gate_a: assert property (
      !globalIrqEnable |=> extPinRequest == 2'h0 && groupRequest == 3'h0)
      else $error("request without the global bit");
   vector_clear_a: assert property (groupVectorTaken[1] |=> ##1 !groupRequest[1])
      else $error("request stands after vector entry");
endmodule
bind epcif_irq_flags epcif_irq_flags_assertions epcif_irq_flags_assertions_i (
   .clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
   .globalIrqEnable, .groupVectorTaken, .extPinRequest, .groupRequest);

//--- ext_pin_change_irq_flags_test.sv
`timescale 1ns/1ps
`include "epcif_cfg.svh"
// ==================================================================
// Self-checking bench of the pin interrupt flag block.
module ext_pin_change_irq_flags_test;
   logic        clk = 1'b0, sysRst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, glob = 1'b0, pready, pslverr, irq, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rdat, seed = 32'h0001767E;
   logic [1:0]  extPin, extTaken = 2'h0, extReq;
   logic [7:0]  group0Inputs, group2Inputs;
   logic [6:0]  group1Inputs;
   logic [2:0]  grpTaken = 3'h0, grpReq;
   logic [24:0] pinTarget = 25'h0000000;
   int          miscompares = 0, comparisons = 0;
   // Register model: index, writable bits, and pin group layout.
   logic [11:0] regIdx[$] = {12'h068, 12'h06B, 12'h06C, 12'h06D, 12'h069, 12'h03D, 12'h072};
   logic [31:0] regMask[$] = {32'h07, 32'hFF, 32'h7F, 32'hFF, 32'h0F, 32'h03, 32'h1F};
   int lsb[3] = '{2, 10, 17};
   int wid[3] = '{8, 7, 8};
   always #5 clk = ~clk;
   epcif_irq_flags epcif_irq_flags_i (.clk, .sys_rst(sysRst), .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .extPin, .group0Inputs,
      .group1Inputs, .group2Inputs, .globalIrqEnable(glob), .extVectorTaken(extTaken),
      .groupVectorTaken(grpTaken), .extPinRequest(extReq), .groupRequest(grpReq), .irq);
   epcif_pin_model epcif_pin_model_i (.clk, .pinTarget, .extPin, .group0Inputs,
      .group1Inputs, .group2Inputs);
   // ==================================================================
   // Helpers.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // The request is held until pready is seen high at an edge.
   task automatic apb(input logic [11:0] i, input logic w, input logic [31:0] d);
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, i << `EPCIF_IDX_SHIFT, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [11:0] i, input logic [31:0] e);
      apb(i, 1'b0, 32'h00000000);
      chk($sformatf("register %h", i), e, rdat);
   endtask
   task automatic end_of_test();
      $display("Mismatches %0d in %0d comparisons", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==================================================================
   // Main sequence.
   initial begin
      repeat (8) @(posedge clk);
      sysRst <= 1'b0;
      repeat (10) @(posedge clk);
      chk("reset outputs", 32'h00000000, {26'h0, extReq, grpReq, irq});
      // Reset values, then writable and reserved bits of each read/write register.
      foreach (regIdx[k]) begin
         rd(regIdx[k], 32'h00000000);
         apb(regIdx[k], 1'b1, 32'hFFFFFFFF);
         rd(regIdx[k], regMask[k]);
      end
      apb(12'h001, 1'b0, 32'h00000000);
      chk("unmapped error", 32'h00000001, {31'h0, err});
      apb(`EPCIF_IDX_IRQ_STATUS, 1'b1, 32'h0000001F);
      rd(`EPCIF_IDX_IRQ_STATUS, 32'h00000000);
      rd(`EPCIF_IDX_IRQ_CLEAR, 32'h00000000);
      glob <= 1'b1;
      // Each group flags only on its own inputs and drives only its own request.
      for (int g = 0; g < 3; g++) begin
         seed = xs(seed);
         pinTarget <= pinTarget ^ (25'h1 << (lsb[g] + seed % wid[g]));
         repeat (12) @(posedge clk);
         rd(`EPCIF_IDX_PC_FLAGS, 32'h1 << g);
         rd(`EPCIF_IDX_IRQ_STATUS, 32'h1 << (g + 2));
         chk("group request", 32'h1 << g, {29'h0, grpReq});
         chk("irq", 32'h00000001, {31'h0, irq});
         if (g == 0) begin
            apb(`EPCIF_IDX_IRQ_ENABLE, 1'b1, 32'h00000000);
            repeat (2) @(posedge clk);
            chk("masked irq", 32'h00000000, {31'h0, irq});
            apb(`EPCIF_IDX_IRQ_ENABLE, 1'b1, 32'h0000001F);
         end
         apb(`EPCIF_IDX_PC_FLAGS, 1'b1, 32'h00000000);
         rd(`EPCIF_IDX_PC_FLAGS, 32'h1 << g);
         if (g == 1) begin
            grpTaken <= 3'h2;
            @(posedge clk);
            grpTaken <= 3'h0;
         end else if (g == 2) begin
            apb(`EPCIF_IDX_IRQ_CLEAR, 1'b1, 32'h00000010);
         end else begin
            apb(`EPCIF_IDX_PC_FLAGS, 1'b1, 32'h1 << g);
         end
         repeat (3) @(posedge clk);
         rd(`EPCIF_IDX_PC_FLAGS, 32'h00000000);
         chk("irq cleared", 32'h00000000, {31'h0, irq});
      end
      // A masked-off input stays silent; a disabled group flags but does not request.
      apb(`EPCIF_IDX_PC_MASK0, 1'b1, 32'h00000000);
      apb(`EPCIF_IDX_PC_ENABLE, 1'b1, 32'h00000003);
      pinTarget <= pinTarget ^ 25'h0020004;
      repeat (12) @(posedge clk);
      rd(`EPCIF_IDX_PC_FLAGS, 32'h00000004);
      chk("disabled group", 32'h00000000, {29'h0, grpReq});
      apb(`EPCIF_IDX_PC_FLAGS, 1'b1, 32'h00000007);
      // Every sense code on both dedicated pins, a rise and then a fall.
      for (int c = 0; c < 4; c++) begin
         apb(`EPCIF_IDX_EXT_SENSE, 1'b1, c * 5);
         pinTarget <= pinTarget | 25'h0000003;
         repeat (12) @(posedge clk);
         rd(`EPCIF_IDX_EXT_FLAGS, (c % 2 == 1) ? 3 : 0);
         apb(`EPCIF_IDX_EXT_FLAGS, 1'b1, 32'h00000003);
         pinTarget <= pinTarget & ~25'h0000003;
         repeat (12) @(posedge clk);
         rd(`EPCIF_IDX_EXT_FLAGS, (c == 1 || c == 2) ? 3 : 0);
         chk("pin request", (c == 3) ? 0 : 3, {30'h0, extReq});
         if (c == 0) begin
            glob <= 1'b0;
            repeat (2) @(posedge clk);
            chk("no global", 32'h00000000, {30'h0, extReq});
            glob <= 1'b1;
         end
         if (c == 1) begin
            extTaken <= 2'h3;
            @(posedge clk);
            extTaken <= 2'h0;
            repeat (2) @(posedge clk);
            rd(`EPCIF_IDX_EXT_FLAGS, 32'h00000000);
         end
         apb(`EPCIF_IDX_EXT_FLAGS, 1'b1, 32'h00000003);
      end
      // A reset in mid-run clears the group enable register and every output.
      sysRst <= 1'b1;
      repeat (8) @(posedge clk);
      sysRst <= 1'b0;
      repeat (10) @(posedge clk);
      rd(`EPCIF_IDX_PC_ENABLE, 32'h00000000);
      chk("mid-run reset", 32'h00000000, {26'h0, extReq, grpReq, irq});
      end_of_test();
   end
   // A hang counts as a mismatch; the whole run needs about five hundred cycles.
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
endmodule
